/* rtl/ldcr_regs.sv */
/*
 * Configuration register bank for words 0x00 and 0x01 of an eight channel
 * LED boost driver. The serial protocol engine in front presents a word
 * address, write data and one-cycle strobes; this block stores, screens
 * and returns the words and drives decoded controls to the power stage.
 * Assumes core_clk from the internal oscillator and rstn from chip enable.
 */
`timescale 1ns/100ps

// Notes on behaviour
// - Word 0 high byte: full-scale current, reset 62h.
// - Word 0 low byte: channel enables, reset 3Fh.
// - Word 1 bits 9:8 select OVP threshold.
// - Word 1 bit 7 selects sync rectifier.
// - Mode 000: analog dimming from PWM pin.
// - Mode 001: analog dimming from register duty.
// - Mode 010: PWM dimming from PWM pin.
// - Mode 011: PWM dimming from register duty.
// - Mode 100 default: mixed dimming from pin.
// - Mode 101: mixed dimming from register duty.
// - Word 1 bit 3 selects current limit.
// - Word 1 bits 2:0 select switching frequency.
// - OTP stored words replace reset defaults.
// - Address 28h grounded, 29h floating select.
module ldcr_regs
(
    // Clock and reset.
    input  wire logic                        core_clk,
    input  wire logic                        rstn,
    // Strap and one-time-programmable defaults.
    input  wire logic                        address_select_float,
    input  wire logic                        otp_valid,
    input  wire logic [15:0]                 otp_word0,
    input  wire logic [15:0]                 otp_word1,
    // Register access from the protocol engine.
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [15:0]                 reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [15:0]                 reg_rdata,
    output logic                             reg_rvalid,
    output logic      [6:0]                  dev_addr,
    // Word 0 controls.
    output logic      [7:0]                  full_scale_current_code,
    output logic      [7:0]                  channel_source_enables,
    // Word 1 controls.
    output logic      [1:0]                  overvoltage_threshold_sel,
    output logic                             sync_rectifier_en,
    output logic      [2:0]                  dimming_mode_sel,
    output logic                             inductor_current_limit_sel,
    output logic      [2:0]                  switching_frequency_sel,
    // Decoded selects.
    output logic      [3:0]                  ovp_onehot,
    output logic      [7:0]                  freq_onehot,
    output logic                             dim_src_reg,
    output logic                             dim_analog,
    output logic                             dim_pwm,
    output logic                             dim_mixed
);
    import ldcr_pkg::*;

    // Stored fields.
    logic [7:0] iset_r;
    logic [7:0] iset_nxt;
    logic [7:0] chen_r;
    logic [7:0] chen_nxt;
    logic [1:0] ovp_r;
    logic [1:0] ovp_nxt;
    logic       sync_r;
    logic       sync_nxt;
    logic [2:0] mod_r;
    logic [2:0] mod_nxt;
    logic       inductor_current_limit_sel_r;
    logic       inductor_current_limit_sel_nxt;
    logic [2:0] fs_r;
    logic [2:0] fs_nxt;
    // One-shot load of the defaults after reset release.
    logic       loaded_r;
    // Read path and device address registers.
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic        rvalid_r;
    logic [6:0]  dev_addr_r;

    // Address decode and write strobes.
    wire        hit_w0 = (reg_addr == LDCR_ADDR_FSCE);
    wire        hit_w1 = (reg_addr == LDCR_ADDR_BDMC);
    wire        wr_w0  = reg_wr && hit_w0;
    wire        wr_w1  = reg_wr && hit_w1;

    // Fields of the incoming write.
    wire [2:0]  wr_mod = reg_wdata[LDCR_MOD_LSB +: 3];
    wire [2:0]  wr_fs  = reg_wdata[LDCR_FS_LSB +: 3];

    // Reserved mode codes 110 and 111 and frequency code 011 are refused.
    // screen undefined codes
    wire        mod_ok = (wr_mod <= LDCR_DIM_MIX_REG);
    wire        fs_ok  = (wr_fs != LDCR_FS_UNDEF);

    // Default words: OTP copy when programmed, else factory values.
    // OTP replaces defaults
    wire [15:0] dflt0 = otp_valid ? otp_word0 : {LDCR_ISET_RST, LDCR_CHEN_RST};
    wire [15:0] dflt1 = otp_valid ? otp_word1 :
                        {6'h00, LDCR_OVP_RST, LDCR_SYNC_RST, LDCR_MOD_RST, LDCR_INDUCTOR_CURRENT_LIMIT_SEL_RST, LDCR_FS_RST};

    // Next field values; the default load happens once after reset release.
    // full-scale current write
    assign iset_nxt = !loaded_r ? dflt0[LDCR_ISET_LSB +: 8] : (wr_w0 ? reg_wdata[LDCR_ISET_LSB +: 8] : iset_r);
    assign chen_nxt = !loaded_r ? dflt0[LDCR_CHEN_LSB +: 8] : (wr_w0 ? reg_wdata[LDCR_CHEN_LSB +: 8] : chen_r);
    assign ovp_nxt  = !loaded_r ? dflt1[LDCR_OVP_LSB +: 2] : (wr_w1 ? reg_wdata[LDCR_OVP_LSB +: 2] : ovp_r);
    assign sync_nxt = !loaded_r ? dflt1[LDCR_SYNC_BIT] : (wr_w1 ? reg_wdata[LDCR_SYNC_BIT] : sync_r);
    assign inductor_current_limit_sel_nxt = !loaded_r ? dflt1[LDCR_INDUCTOR_CURRENT_LIMIT_SEL_BIT] : (wr_w1 ? reg_wdata[LDCR_INDUCTOR_CURRENT_LIMIT_SEL_BIT] : inductor_current_limit_sel_r);
    assign mod_nxt  = !loaded_r ? dflt1[LDCR_MOD_LSB +: 3] : ((wr_w1 && mod_ok) ? wr_mod : mod_r);
    assign fs_nxt   = !loaded_r ? dflt1[LDCR_FS_LSB +: 3] : ((wr_w1 && fs_ok) ? wr_fs : fs_r);

    // Read mux; unmapped words read zero.
    // reserved bits zero
    assign rdata_nxt = hit_w0 ? {iset_r, chen_r} :
                       hit_w1 ? {6'h00, ovp_r, sync_r, mod_r, inductor_current_limit_sel_r, fs_r} : 16'h0000;

    // Field registers. Reset uses factory constants; OTP words arrive
    // from a port so they are taken by the clocked load just after release.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            iset_r   <= LDCR_ISET_RST;
            chen_r   <= LDCR_CHEN_RST;
            ovp_r    <= LDCR_OVP_RST;
            sync_r   <= LDCR_SYNC_RST;
            mod_r    <= LDCR_MOD_RST;
            inductor_current_limit_sel_r   <= LDCR_INDUCTOR_CURRENT_LIMIT_SEL_RST;
            fs_r     <= LDCR_FS_RST;
            loaded_r <= 1'b0;
        end
        else
        begin
            iset_r   <= iset_nxt;
            chen_r   <= chen_nxt;
            ovp_r    <= ovp_nxt;
            sync_r   <= sync_nxt;
            mod_r    <= mod_nxt;
            inductor_current_limit_sel_r   <= inductor_current_limit_sel_nxt;
            fs_r     <= fs_nxt;
            loaded_r <= 1'b1;
        end
    end

    // Read data and its valid pulse, one cycle after the read strobe.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata_r  <= 16'h0000;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rvalid_r <= reg_rd;
            if (reg_rd)
            begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    // Device address from the strap, sampled each cycle after release.
    // strap selects address
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dev_addr_r <= LDCR_I2C_ADDR_BASE;
        end
        else
        begin
            dev_addr_r <= LDCR_I2C_ADDR_BASE | {6'h00, address_select_float};
        end
    end

    // Decoded selects; registered so top outputs come from flip-flops.
    logic [3:0] ovp_oh_w;
    logic [7:0] freq_oh_w;
    logic       src_w;
    logic       ana_w;
    logic       pwm_w;
    logic       mix_w;

    ldcr_decode u_decode
    (
        .ovp_sel     (ovp_nxt),
        .mode_sel    (mod_nxt),
        .freq_sel    (fs_nxt),
        .ovp_onehot  (ovp_oh_w),
        .freq_onehot (freq_oh_w),
        .dim_src_reg (src_w),
        .dim_analog  (ana_w),
        .dim_pwm     (pwm_w),
        .dim_mixed   (mix_w)
    );

    // Decoded registers track the field registers in the same cycle.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ovp_onehot  <= 4'h4;
            freq_onehot <= 8'h04;
            dim_src_reg <= 1'b0;
            dim_analog  <= 1'b0;
            dim_pwm     <= 1'b0;
            dim_mixed   <= 1'b1;
        end
        else
        begin
            ovp_onehot  <= ovp_oh_w;
            freq_onehot <= freq_oh_w;
            dim_src_reg <= src_w;
            dim_analog  <= ana_w;
            dim_pwm     <= pwm_w;
            dim_mixed   <= mix_w;
        end
    end

    // Field outputs straight from their registers.
    assign full_scale_current_code    = iset_r;
    assign channel_source_enables     = chen_r;
    assign overvoltage_threshold_sel  = ovp_r;
    assign sync_rectifier_en          = sync_r;
    assign dimming_mode_sel           = mod_r;
    assign inductor_current_limit_sel = inductor_current_limit_sel_r;
    assign switching_frequency_sel    = fs_r;
    assign reg_rdata                  = rdata_r;
    assign reg_rvalid                 = rvalid_r;
    assign dev_addr                   = dev_addr_r;

endmodule

/* rtl/ldcr_pkg.sv */
/*
 * Package for the LED driver configuration register bank.
 * Holds word addresses, field positions, reset values and decode codes.
 * Assumes nothing of its surroundings.
 */
package ldcr_pkg;

    // Word addresses of the two configuration registers.
    localparam logic [7:0] LDCR_ADDR_FSCE = 8'h00;
    localparam logic [7:0] LDCR_ADDR_BDMC = 8'h01;

    // Field positions in word 0x00.
    localparam int LDCR_ISET_LSB = 8;
    localparam int LDCR_CHEN_LSB = 0;

    // Field positions in word 0x01.
    localparam int LDCR_OVP_LSB  = 8;
    localparam int LDCR_SYNC_BIT = 7;
    localparam int LDCR_MOD_LSB  = 4;
    localparam int LDCR_INDUCTOR_CURRENT_LIMIT_SEL_BIT = 3;
    localparam int LDCR_FS_LSB   = 0;

    // Factory reset values of each field.
    localparam logic [7:0] LDCR_ISET_RST = 8'h62;
    localparam logic [7:0] LDCR_CHEN_RST = 8'h3f;
    localparam logic [1:0] LDCR_OVP_RST  = 2'h2;
    localparam logic       LDCR_SYNC_RST = 1'h1;
    localparam logic [2:0] LDCR_MOD_RST  = 3'h4;
    localparam logic       LDCR_INDUCTOR_CURRENT_LIMIT_SEL_RST = 1'h1;
    localparam logic [2:0] LDCR_FS_RST   = 3'h2;

    // Device address for address_select_pin grounded; floating adds one.
    localparam logic [6:0] LDCR_I2C_ADDR_BASE = 7'h28;

    // Host must wait this long after enable before register access.
    localparam int LDCR_EN_READY_MS = 2;

    // Undefined codes that are refused on write.
    localparam logic [2:0] LDCR_FS_UNDEF = 3'h3;

    // Dimming modes as decoded from the mode field.
    typedef enum logic [2:0]
    {
        LDCR_DIM_ANA_EXT,
        LDCR_DIM_ANA_REG,
        LDCR_DIM_PWM_EXT,
        LDCR_DIM_PWM_REG,
        LDCR_DIM_MIX_EXT,
        LDCR_DIM_MIX_REG
    } ldcr_dim_mode_t;

endpackage

/* rtl/ldcr_decode.sv */
/*
 * Combinational decode of the boost and dimming fields into one-hot
 * selects for the analog power stage and dimming logic.
 * Assumes the fields are the bank's next field values, with written codes already screened for bad codes.
 */
`timescale 1ns/100ps
module ldcr_decode
(
    // Stored fields.
    input  wire logic [1:0] ovp_sel,
    input  wire logic [2:0] mode_sel,
    input  wire logic [2:0] freq_sel,
    // Decoded selects.
    output logic      [3:0] ovp_onehot,
    output logic      [7:0] freq_onehot,
    output logic            dim_src_reg,
    output logic            dim_analog,
    output logic            dim_pwm,
    output logic            dim_mixed
);
    import ldcr_pkg::*;

    // One-hot OVP level: 24 V, 31 V, 37.5 V, 46 V in bits 0..3.
    // threshold decode
    assign ovp_onehot  = 4'h1 << ovp_sel;

    // One-hot frequency: 350k,500k,650k,-,950k,1.2M,1.8M,2.4M.
    // frequency decode
    assign freq_onehot = 8'h01 << freq_sel;

    // Odd codes take the duty from the register, even ones from the pin.
    // register duty source
    assign dim_src_reg = mode_sel[0];

    assign dim_analog  = (mode_sel == LDCR_DIM_ANA_EXT) || (mode_sel == LDCR_DIM_ANA_REG);
    assign dim_pwm     = (mode_sel == LDCR_DIM_PWM_EXT) || (mode_sel == LDCR_DIM_PWM_REG);
    assign dim_mixed   = (mode_sel == LDCR_DIM_MIX_EXT) || (mode_sel == LDCR_DIM_MIX_REG);

endmodule

/* tb/ldcr_chk.sv */
/* Port-level checker for the configuration register bank.
   Assumes it is bound to ldcr_regs and sees only that module's ports. */
`timescale 1ns/100ps
module ldcr_chk
(
    // Clock, reset and strap.
    input logic        core_clk,
    input logic        rstn,
    input logic        address_select_float,
    // Register access.
    input logic [7:0]  reg_addr,
    input logic [15:0] reg_wdata,
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [15:0] reg_rdata,
    input logic        reg_rvalid,
    input logic [6:0]  dev_addr,
    // Fields and decoded selects.
    input logic [7:0]  full_scale_current_code,
    input logic [7:0]  channel_source_enables,
    input logic [1:0]  overvoltage_threshold_sel,
    input logic        sync_rectifier_en,
    input logic [2:0]  dimming_mode_sel,
    input logic        inductor_current_limit_sel,
    input logic [2:0]  switching_frequency_sel,
    input logic [3:0]  ovp_onehot,
    input logic [7:0]  freq_onehot,
    input logic        dim_src_reg,
    input logic        dim_analog,
    input logic        dim_pwm,
    input logic        dim_mixed
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Write strobes aimed at each word.
    wire w0 = reg_wr && reg_addr == 8'h00;
    wire w1 = reg_wr && reg_addr == 8'h01;
    a_word0_store: assert property (w0 |=>
        {full_scale_current_code, channel_source_enables} == $past(reg_wdata)) else $error("word0 not stored");
    a_opt_store: assert property (w1 |=> {overvoltage_threshold_sel, sync_rectifier_en,
        inductor_current_limit_sel} == {$past(reg_wdata[9:7]), $past(reg_wdata[3])}) else $error("option lost");
    a_ovp_decode: assert property (ovp_onehot == 4'h1 << overvoltage_threshold_sel)
        else $error("ovp decode wrong");
    a_freq_decode: assert property (freq_onehot == 8'h01 << switching_frequency_sel)
        else $error("freq decode wrong");
    a_dim_decode: assert property ({dim_src_reg, dim_analog, dim_pwm, dim_mixed} ==
        {dimming_mode_sel[0], dimming_mode_sel[2:1] == 2'h0, dimming_mode_sel[2:1] == 2'h1,
        dimming_mode_sel[2:1] == 2'h2}) else $error("dim decode wrong");
    a_freq_undef: assert property (w1 && reg_wdata[2:0] == 3'h3 |=> $stable(switching_frequency_sel))
        else $error("bad freq taken");
    a_mode_undef: assert property (w1 && reg_wdata[6:5] == 2'h3 |=> $stable(dimming_mode_sel))
        else $error("bad mode taken");
    a_resv_read: assert property (reg_rd && reg_addr == 8'h01 |=> reg_rvalid && reg_rdata[15:10] == 6'h00)
        else $error("reserved bits set");
    a_dev_addr: assert property ($past(rstn) |-> dev_addr == {6'h14, $past(address_select_float)})
        else $error("device address wrong");
    cover property (w1 && reg_wdata[2:0] == 3'h3);
    cover property (reg_rd && reg_addr > 8'h01);
    cover property (dim_mixed && dim_src_reg);
endmodule
bind ldcr_regs ldcr_chk ldcr_chk_i (.*);

/* tb/ldcr_host.sv */
/* Host model standing in for the serial engine at the register port.
   Assumes it shares core_clk and rstn with the bank. */
`timescale 1ns/100ps
module ldcr_host
(
    // Clock and reset.
    input  logic        core_clk,
    input  logic        rstn,
    // Register port.
    output logic [7:0]  reg_addr,
    output logic [15:0] reg_wdata,
    output logic        reg_wr,
    output logic        reg_rd,
    input  logic [15:0] reg_rdata,
    input  logic        reg_rvalid
);
    int up_r;  // Cycles since chip enable rose.
    initial
    begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    end
    always @(posedge core_clk or negedge rstn)
        if (!rstn)
            up_r <= 0;
        else if (up_r < 20000)
            up_r <= up_r + 1;
    // No access until 2 ms after enable, then launch just after a falling edge.
    task automatic start(input logic [7:0] a);
        while (up_r < 20000)
            @(negedge core_clk);
        @(negedge core_clk);
        reg_addr = a;
    endtask
    // Lines are scrambled after release, since nothing holds them then.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        start(a);
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        {reg_wr, reg_wdata, reg_addr} = {1'b0, ~d, ~a};
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        int n;
        start(a);
        reg_rd = 1'b1;
        @(negedge core_clk);
        {reg_rd, reg_addr} = {1'b0, ~a};
        for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++)
            @(negedge core_clk);
        d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
    endtask
endmodule

/* tb/ldcr_regs_tb.sv */
/* Self-checking bench for the configuration register bank.
   Assumes ldcr_host drives the register port and ldcr_chk is bound. */
`timescale 1ns/100ps
module ldcr_regs_tb;
    logic        core_clk, rstn, address_select_float, otp_valid, reg_wr, reg_rd, reg_rvalid;
    logic [15:0] otp_word0, otp_word1, reg_wdata, reg_rdata, got;
    logic [7:0]  reg_addr, full_scale_current_code, channel_source_enables, freq_onehot;
    logic        sync_rectifier_en, inductor_current_limit_sel, dim_src_reg, dim_analog, dim_pwm, dim_mixed;
    logic [6:0]  dev_addr;
    logic [3:0]  ovp_onehot;
    logic [2:0]  dimming_mode_sel, switching_frequency_sel, m;
    logic [1:0]  overvoltage_threshold_sel;
    int          mismatches = 0, cmp_count = 0, i;
    ldcr_regs ldcr_regs_i (.*);
    ldcr_host ldcr_host_i (.*);
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string s);
        cmp_count++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD t=%0t %s got %h exp %h", $time, s, g, e);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] e, input string s);
        ldcr_host_i.rd(a, got);
        chk(got, e, s);
    endtask
    task automatic do_reset;
        rstn = 1'b0;
        repeat (8) @(negedge core_clk);
        rstn = 1'b1;
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        {address_select_float, otp_valid, otp_word0, otp_word1} = '0;
        do_reset();
        rdchk(8'h00, 16'h623f, "word0 reset");
        rdchk(8'h01, 16'h02ca, "word1 reset");
        chk({9'h0, dev_addr}, 16'h0028, "address grounded");
        ldcr_host_i.wr(8'h00, 16'hff00);
        rdchk(8'h00, 16'hff00, "word0 high");
        ldcr_host_i.wr(8'h00, 16'h00ff);
        ldcr_host_i.wr(8'h02, 16'h1234);
        rdchk(8'h02, 16'h0000, "unmapped read");
        rdchk(8'h00, 16'h00ff, "word0 low");
        $display("test word0 done");
        // Codes 110 and 111 must leave mode 101 in place.
        for (i = 0; i < 8; i++)
        begin
            if (i < 6)
                m = 3'(i);
            ldcr_host_i.wr(8'h01, {6'h3f, 2'h1, 1'b0, 3'(i), 1'b0, 3'h1});
            rdchk(8'h01, {6'h00, 2'h1, 1'b0, m, 1'b0, 3'h1}, "mode word");
            chk({12'h0, dim_src_reg, dim_analog, dim_pwm, dim_mixed}, {12'h0, m[0], m[2:1] == 2'h0,
                m[2:1] == 2'h1, m[2:1] == 2'h2}, "mode decode");
        end
        $display("test modes done");
        // Code 011 must leave 650 kHz in place.
        for (i = 0; i < 8; i++)
        begin
            if (i != 3)
                m = 3'(i);
            ldcr_host_i.wr(8'h01, {6'h00, 2'(i), 1'(i < 5), 3'h4, 1'b1, 3'(i)});
            rdchk(8'h01, {6'h00, 2'(i), 1'(i < 5), 3'h4, 1'b1, m}, "freq word");
            chk({4'h0, ovp_onehot, freq_onehot}, {4'h0, 4'h1 << i[1:0], 8'h01 << m}, "onehot");
        end
        $display("test frequency done");
        // Stored defaults replace factory values across a mid-run reset.
        {otp_valid, otp_word0, otp_word1, address_select_float} = {1'b1, 16'h5aa5, 16'hfd35, 1'b1};
        do_reset();
        rdchk(8'h00, 16'h5aa5, "stored word0");
        rdchk(8'h01, 16'h0135, "stored word1");
        chk({9'h0, dev_addr}, 16'h0029, "address floating");
        $display("test stored defaults done");
        finish_test();
    end
    initial
    begin
        #6_000_000;
        mismatches++;
        $display("BAD t=%0t watchdog expired", $time);
        finish_test();
    end
endmodule
